// ### design/sync_ctrl_pkg.sv
package sync_ctrl_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] addr_ctrl = 8'h20;
  localparam logic [7:0] addr_cfg_a = 8'h21;
  localparam logic [7:0] addr_cfg_b = 8'h22;
  localparam logic [7:0] addr_window = 8'h23;
  localparam logic [7:0] addr_activity = 8'h24;
  localparam logic [7:0] addr_polarity = 8'h25;
  localparam int addr_lsb = 2;
  localparam int addr_w = 8;
  // ****************************************************
  // control fields and reset values
  // ****************************************************
  localparam int bit_all_hiz = 5;
  localparam int bit_green_hiz = 4;
  localparam int bit_field_pol = 3;
  localparam int bit_pll_filt = 2;
  localparam int bit_sp_regen = 1;
  localparam logic [7:0] ctrl_reset = 8'h08;
  localparam logic [7:0] cfg_a_reset = 8'h00;
  localparam logic [7:0] cfg_b_reset = 8'h00;
  localparam logic [7:0] window_reset = 8'h0a;
  localparam logic [31:0] unmapped_data = 32'h0000_0000;
  // ****************************************************
  // monitored inputs: index equals activity status bit; polarity packs bits 7:4, then ext and clamp
  // ****************************************************
  localparam int mon_n = 8;
  localparam int mon_line_a = 7;
  localparam int mon_line_b = 6;
  localparam int mon_frame_a = 5;
  localparam int mon_frame_b = 4;
  localparam int mon_green_a = 3;
  localparam int mon_green_b = 2;
  localparam int mon_ext = 1;
  localparam int mon_clamp = 0;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int clk_period_ns = 100;
  localparam int window_step_ns = 25;
  localparam int idle_timeout_ms = 100;
  localparam int idle_timeout_cyc = idle_timeout_ms * 1000000 / clk_period_ns;
  localparam int cnt_w = 21;
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_ack = 2'b01
  } bus_state_e;
endpackage

// ### design/sync_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// activity and polarity monitor for one input
// ****************************************************
module sync_monitor
  import sync_ctrl_pkg::*;
#(
  parameter int timeout_cyc = idle_timeout_cyc
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sync_i,
  output logic active_o,
  output logic polarity_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [1:0] fill;
    logic [cnt_w-1:0] idle;
    logic [cnt_w-1:0] hi_cnt;
    logic [cnt_w-1:0] lo_cnt;
    logic active;
    logic polarity;
  } mon_s;
  mon_s r, next_r;
  always_comb begin
    next_r = r;
    next_r.s1 = sync_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (!(&r.fill)) begin
      // synchroniser still filling after reset: its reset level is not an edge
      next_r.fill = r.fill + 2'b01;
    end else if (r.s2 != r.s3) begin
      next_r.idle = '0;
      next_r.active = 1'b1;
      // shorter phase is the pulse: pulse high means positive polarity
      if (r.s2 == 1'b0) begin
        next_r.polarity = (r.hi_cnt < r.lo_cnt);
        next_r.lo_cnt = '0;
      end else begin
        next_r.hi_cnt = '0;
      end
    end else begin
      if (r.idle >= cnt_w'(timeout_cyc - 1)) begin
        next_r.active = 1'b0;
      end else begin
        next_r.idle = r.idle + 1'b1;
      end
      if (r.s2 && r.hi_cnt != '1) next_r.hi_cnt = r.hi_cnt + 1'b1;
      if (!r.s2 && r.lo_cnt != '1) next_r.lo_cnt = r.lo_cnt + 1'b1;
    end
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign active_o = r.active;
  assign polarity_o = r.polarity;
endmodule
`default_nettype wire

// ### design/sync_output_ctrl_status.sv
`timescale 1ns/1ps
`default_nettype none
module sync_output_ctrl_status
  import sync_ctrl_pkg::*;
#(
  parameter int timeout_cyc = idle_timeout_cyc
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [addr_w-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic line_sync_in_a_i,
  input wire logic line_sync_in_b_i,
  input wire logic frame_sync_in_a_i,
  input wire logic frame_sync_in_b_i,
  input wire logic green_sync_in_a_i,
  input wire logic green_sync_in_b_i,
  input wire logic ext_clock_or_freeze_pin_i,
  input wire logic clamp_in_i,
  input wire logic line_sel_b_i,
  input wire logic regen_line_sync_i,
  input wire logic field_even_i,
  output logic field_out_o,
  output logic field_out_oe_n_o,
  output logic data_out_oe_n_o,
  output logic green_sync_slicer_out_o,
  output logic green_sync_slicer_out_oe_n_o,
  output logic pll_ref_o,
  output logic sp_sync_o
);
  // ****************************************************
  // pin synchronisers and monitors
  // ****************************************************
  logic [mon_n-1:0] pins;
  logic [mon_n-1:0] act;
  logic [mon_n-1:0] pol;
  assign pins[mon_line_a] = line_sync_in_a_i;
  assign pins[mon_line_b] = line_sync_in_b_i;
  assign pins[mon_frame_a] = frame_sync_in_a_i;
  assign pins[mon_frame_b] = frame_sync_in_b_i;
  assign pins[mon_green_a] = green_sync_in_a_i;
  assign pins[mon_green_b] = green_sync_in_b_i;
  assign pins[mon_ext] = ext_clock_or_freeze_pin_i;
  assign pins[mon_clamp] = clamp_in_i;
  for (genvar g = 0; g < mon_n; g++) begin : g_mon
    sync_monitor #(
      .timeout_cyc(timeout_cyc)
    ) u_mon (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .sync_i(pins[g]),
      .active_o(act[g]),
      .polarity_o(pol[g])
    );
  end
  function automatic logic hit(input logic [addr_w-1:0] a, input logic [7:0] off);
    hit = (a == addr_w'({off, 2'b00}));
  endfunction
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    bus_state_e bus;
    logic wreq;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] window;
    logic [1:0] line_a_s;
    logic [1:0] line_b_s;
    logic line_prev;
    logic [1:0] regen_s;
    logic [1:0] even_s;
    logic [7:0] win_cnt;
    logic win_open;
    logic win_run;
    logic filt;
    logic field;
    logic field_oe_n;
    logic data_oe_n;
    logic green_out;
    logic green_oe_n;
    logic pll_ref;
    logic sp_sync;
  } top_s;
  top_s r, next_r;
  logic raw_line;
  logic regen_edge;
  logic [7:0] win_half;
  always_comb begin
    next_r = r;
    raw_line = line_sel_b_i ? r.line_b_s[1] : r.line_a_s[1];
    regen_edge = r.regen_s[1];
    // a filter step is a quarter of a clock here, so win_half rounds the window up to whole cycles
    win_half = 8'((int'(r.window) * window_step_ns + clk_period_ns - 1) / clk_period_ns);
    // bus slave: one wait cycle, then answer
    case (r.bus)
      bus_idle: begin
        if (avs_read_i || avs_write_i) begin
          next_r.bus = bus_ack;
          next_r.wreq = 1'b0;
          next_r.rdata = unmapped_data;
          if (avs_write_i && avs_byteenable_i[0]) begin
            if (hit(avs_address_i, addr_ctrl)) next_r.ctrl = avs_writedata_i[7:0];
            if (hit(avs_address_i, addr_cfg_a)) next_r.cfg_a = avs_writedata_i[7:0];
            if (hit(avs_address_i, addr_cfg_b)) next_r.cfg_b = avs_writedata_i[7:0];
            if (hit(avs_address_i, addr_window)) next_r.window = avs_writedata_i[7:0];
          end
          if (avs_read_i) begin
            if (hit(avs_address_i, addr_ctrl)) next_r.rdata[7:0] = r.ctrl;
            if (hit(avs_address_i, addr_cfg_a)) next_r.rdata[7:0] = r.cfg_a;
            if (hit(avs_address_i, addr_cfg_b)) next_r.rdata[7:0] = r.cfg_b;
            if (hit(avs_address_i, addr_window)) next_r.rdata[7:0] = r.window;
            if (hit(avs_address_i, addr_activity)) next_r.rdata[7:0] = act;
            if (hit(avs_address_i, addr_polarity)) begin
              next_r.rdata[7:0] = {pol[mon_line_a], pol[mon_line_b], pol[mon_frame_a],
                pol[mon_frame_b], pol[mon_ext], pol[mon_clamp], 2'b00};
            end
          end
        end
      end
      bus_ack: begin
        next_r.bus = bus_idle;
        next_r.wreq = 1'b1;
      end
      default: begin
        next_r.bus = bus_idle;
        next_r.wreq = 1'b1;
      end
    endcase
    // sync filter: window is held open while regen is high and closes win_half + 1 cycles after it falls
    // both line pins are synchronised before the selector reads them
    next_r.line_a_s = {r.line_a_s[0], line_sync_in_a_i};
    next_r.line_b_s = {r.line_b_s[0], line_sync_in_b_i};
    next_r.line_prev = raw_line;
    next_r.regen_s = {r.regen_s[0], regen_line_sync_i};
    next_r.even_s = {r.even_s[0], field_even_i};
    if (regen_edge) begin
      next_r.win_run = 1'b1;
      next_r.win_open = 1'b1;
      next_r.win_cnt = '0;
    end else if (r.win_run) begin
      next_r.win_cnt = r.win_cnt + 8'h01;
      if (r.win_cnt >= win_half) begin
        next_r.win_open = 1'b0;
        next_r.win_run = 1'b0;
      end
    end
    // an aligned raw edge lands in the same cycle as the regenerated one
    if ((r.win_open || regen_edge) && (raw_line != r.line_prev)) next_r.filt = raw_line;
    next_r.pll_ref = r.ctrl[bit_pll_filt] ? r.filt : raw_line;
    next_r.sp_sync = r.ctrl[bit_sp_regen] ? regen_edge : raw_line;
    next_r.field = r.even_s[1] ~^ r.ctrl[bit_field_pol];
    next_r.data_oe_n = r.ctrl[bit_all_hiz];
    next_r.field_oe_n = r.ctrl[bit_all_hiz];
    next_r.green_out = raw_line;
    next_r.green_oe_n = r.ctrl[bit_green_hiz];
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.bus <= bus_idle;
      r.wreq <= 1'b1;
      r.ctrl <= ctrl_reset;
      r.cfg_a <= cfg_a_reset;
      r.cfg_b <= cfg_b_reset;
      r.window <= window_reset;
    end else begin
      r <= next_r;
    end
  end
  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = r.wreq;
  assign field_out_o = r.field;
  assign field_out_oe_n_o = r.field_oe_n;
  assign data_out_oe_n_o = r.data_oe_n;
  assign green_sync_slicer_out_o = r.green_out;
  assign green_sync_slicer_out_oe_n_o = r.green_oe_n;
  assign pll_ref_o = r.pll_ref;
  assign sp_sync_o = r.sp_sync;
endmodule
`default_nettype wire

// ### dv/sync_output_ctrl_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// bus and output control properties
// ****************************************************
module sync_ctrl_checker
  import sync_ctrl_pkg::*;
#(
  parameter int timeout_cyc = idle_timeout_cyc
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [addr_w-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic field_even_i,
  input wire logic field_out_o,
  input wire logic field_out_oe_n_o,
  input wire logic data_out_oe_n_o,
  input wire logic green_sync_slicer_out_oe_n_o
);
  logic [2:0] ctl;
  logic take_w;
  assign take_w = avs_write_i && avs_waitrequest_o && avs_byteenable_i[0]
    && avs_address_i == (addr_ctrl << addr_lsb);
  // shadow of control bits 5:3
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctl <= ctrl_reset[5:3];
    end else if (take_w) begin
      ctl <= avs_writedata_i[5:3];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_ack_next;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no answer");
  property p_ack_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("answer too long");
  property p_rd_hold;
    !$past((avs_read_i || avs_write_i) && avs_waitrequest_o) |-> $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_upper;
    avs_readdata_o[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper data set");
  property p_all_hiz;
    !$past(rst_i) |-> data_out_oe_n_o == $past(ctl[2]);
  endproperty
  a_all_hiz: assert property (p_all_hiz) else $error("data enable wrong");
  property p_field_oe;
    !$past(rst_i) |-> field_out_oe_n_o == $past(ctl[2]);
  endproperty
  a_field_oe: assert property (p_field_oe) else $error("field enable wrong");
  property p_green_hiz;
    !$past(rst_i) |-> green_sync_slicer_out_oe_n_o == $past(ctl[1]);
  endproperty
  a_green_hiz: assert property (p_green_hiz) else $error("slicer enable wrong");
  property p_field_pol;
    !$past(rst_i, 3) |-> field_out_o == ($past(field_even_i, 3) ~^ $past(ctl[0]));
  endproperty
  a_field_pol: assert property (p_field_pol) else $error("field level wrong");
  c_ctrl_write: cover property (take_w);
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_field_rise: cover property ($rose(field_out_o));
endmodule
bind sync_output_ctrl_status sync_ctrl_checker #(.timeout_cyc(timeout_cyc)) i_sync_ctrl_checker (.*);
`default_nettype wire

// ### dv/sync_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// sync sources: 3 of 32 cycles active, static when off
// skew moves the pin pulses half a period away from regen
// ****************************************************
module sync_source_model (
  input wire logic clock_i,
  input wire logic skew_i,
  input wire logic [7:0] en_i,
  input wire logic [7:0] pol_i,
  output logic [7:0] pins_o,
  output logic regen_o
);
  logic [4:0] cnt = 5'h00;
  always @(posedge clock_i) begin
    cnt <= cnt + 5'h01;
  end
  logic pulse;
  assign regen_o = cnt < 5'h03;
  assign pulse = (cnt ^ {skew_i, 4'h0}) < 5'h03;
  assign pins_o = ~(pol_i ^ ({8{pulse}} & en_i));
endmodule
`default_nettype wire

// ### dv/sync_output_ctrl_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sync_output_ctrl_status_bench;
  import sync_ctrl_pkg::*;
  localparam int tmo = 64;
  logic clock_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic line_sel_b_i = 1'b0, field_even_i = 1'b0, pl, sy, gs, skew = 1'b0;
  logic [7:0] en = 8'h00, pol = 8'h00, q;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, field_out_o, field_out_oe_n_o, data_out_oe_n_o, pll_ref_o;
  wire green_sync_slicer_out_o, green_sync_slicer_out_oe_n_o, sp_sync_o, regen_line_sync_i;
  wire line_sync_in_a_i, line_sync_in_b_i, frame_sync_in_a_i, frame_sync_in_b_i;
  wire green_sync_in_a_i, green_sync_in_b_i, ext_clock_or_freeze_pin_i, clamp_in_i;
  int bad_count = 0, cmp_count = 0;
  sync_output_ctrl_status #(.timeout_cyc(tmo)) i_sync_output_ctrl_status (.*);
  sync_source_model i_sync_source_model (.clock_i(clock_i), .en_i(en), .pol_i(pol),
    .skew_i(skew), .regen_o(regen_line_sync_i), .pins_o({line_sync_in_a_i, line_sync_in_b_i,
    frame_sync_in_a_i, frame_sync_in_b_i, green_sync_in_a_i, green_sync_in_b_i,
    ext_clock_or_freeze_pin_i, clamp_in_i}));
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  // ****************************************************
  // bus tasks
  // ****************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= {a[5:0], 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= b;
    // look in mid-cycle: what stands there is what the next rising edge samples
    do begin
      @(negedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      bad_count++;
      $display("[FAIL] %0t bus timeout", $time);
      complete_run();
    end
    q = avs_readdata_o[7:0];
    @(posedge clock_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hf);
    chk(q, exp);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    field_even_i <= 1'b1;
    rd(addr_ctrl, ctrl_reset);
    rd(addr_cfg_a, cfg_a_reset);
    rd(addr_cfg_b, cfg_b_reset);
    rd(addr_window, window_reset);
    rd(addr_activity, 8'h00);
    rd(8'h30, 8'h00);
    chk({6'h0, data_out_oe_n_o, green_sync_slicer_out_oe_n_o}, 8'h00);
    $display("test reset done");
    wrr(addr_ctrl, 8'h2b);
    repeat (2) @(negedge clock_i);
    chk({4'h0, field_out_o, data_out_oe_n_o, field_out_oe_n_o,
      green_sync_slicer_out_oe_n_o}, 8'h0e);
    wrr(addr_ctrl, 8'h13);
    repeat (2) @(negedge clock_i);
    chk({4'h0, field_out_o, data_out_oe_n_o, field_out_oe_n_o,
      green_sync_slicer_out_oe_n_o}, 8'h01);
    bus(1'b1, addr_ctrl, 8'hff, 4'h0);
    rd(addr_ctrl, 8'h13);
    wrr(addr_window, 8'h05);
    rd(addr_window, 8'h05);
    wrr(addr_cfg_a, cfg_a_reset);
    wrr(addr_ctrl, 8'h0b);
    $display("test control done");
    for (int k = 0; k < 2; k++) begin
      pol <= k ? 8'h5a : 8'ha5;
      en <= 8'hff;
      repeat (2 * tmo) @(posedge clock_i);
      rd(addr_activity, 8'hff);
      wrr(addr_activity, 8'h00);
      rd(addr_activity, 8'hff);
      bus(1'b0, addr_polarity, 8'h00, 4'hf);
      chk(q & 8'hfc, {pol[7:4], pol[1:0], 2'b00});
      en <= 8'h00;
      repeat (tmo + 16) @(posedge clock_i);
      rd(addr_activity, 8'h00);
    end
    $display("test status done");
    // k 3 passes aligned pulses through the filter, k 4 offers only pulses outside it
    for (int k = 0; k < 5; k++) begin
      en <= 8'h40;
      pol <= 8'hff;
      line_sel_b_i <= k == 1 || k >= 3;
      skew <= k == 4;
      wrr(addr_ctrl, k < 2 ? 8'h01 : k == 2 ? 8'h03 : 8'h05);
      repeat (8) @(posedge clock_i);
      pl = 1'b0;
      sy = 1'b0;
      gs = 1'b0;
      repeat (64) begin
        @(negedge clock_i);
        pl = pl | pll_ref_o;
        sy = sy | sp_sync_o;
        gs = gs | green_sync_slicer_out_o;
      end
      chk({5'h0, gs, pl, sy}, k == 0 ? 8'h00 : k == 2 ? 8'h01 : k == 4 ? 8'h05 : 8'h07);
    end
    $display("test routing done");
    complete_run();
  end
endmodule
`default_nettype wire
